//--- core/sgs_consts.vh
// Constants for the synchronous-rectifier gate supervisor
`ifndef SGS_CONSTS_VH
`define SGS_CONSTS_VH

// ----------------------------------------------------------------
// Timebase
// ----------------------------------------------------------------
`define SGS_CLK_MHZ          200
`define SGS_TICK_CYC         (`SGS_CLK_MHZ)
`define SGS_T_STEP_NS        500
`define SGS_STEP_CYC         ((`SGS_T_STEP_NS * `SGS_CLK_MHZ) / 1000)
`define SGS_T_DEAD_CVH_NS    600
`define SGS_T_DEAD_CVL1_NS   570
`define SGS_T_DEAD_CVL2_NS   850
`define SGS_DEAD_CVH_CYC     ((`SGS_T_DEAD_CVH_NS * `SGS_CLK_MHZ) / 1000)
`define SGS_DEAD_CVL1_CYC    ((`SGS_T_DEAD_CVL1_NS * `SGS_CLK_MHZ) / 1000)
`define SGS_DEAD_CVL2_CYC    ((`SGS_T_DEAD_CVL2_NS * `SGS_CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// Durations in timebase ticks of 1 us, then exit and resume counts in switching cycles
// ----------------------------------------------------------------
`define SGS_T_GAP_ENTER_US   330
`define SGS_T_GAP_EXIT_US    150
`define SGS_T_STUCK_US       20000
`define SGS_T_ENABLE_US      32000
`define SGS_T_PWRUP_US       500
`define SGS_T_MISS_CV_US     24
`define SGS_T_MISS_CC_US     50
`define SGS_T_LINE_UP_US     18000
`define SGS_T_LINE_DN_US     15
`define SGS_EXIT_CYCLES      257
`define SGS_RESUME_CYCLES    256

// ----------------------------------------------------------------
// Synchroniser input positions
// ----------------------------------------------------------------
`define SGS_IN_DRAIN         0
`define SGS_IN_PREV90_LOW    1
`define SGS_IN_BETWEEN       2
`define SGS_IN_OUT_LOW       3
`define SGS_IN_OUT_DROP      4
`define SGS_IN_OVER_7V       5
`define SGS_IN_ABOVE_ON      6
`define SGS_IN_INPUT_LOW     7
`define SGS_IN_LINE_HIGH     8
`define SGS_IN_CC_MODE       9
`define SGS_IN_LOW_STRAP     10
`define SGS_IN_GAIN_GND      11
`define SGS_IN_COUNT         12

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SGS_ADDR_CTRL        8'h00
`define SGS_ADDR_STATUS      8'h04
`define SGS_ADDR_ONTIME      8'h08
`define SGS_ADDR_PERIOD      8'h0c
`define SGS_ADDR_EVENT       8'h10
`define SGS_CTRL_RESET       2'h1
`define SGS_EV_PREV90        0
`define SGS_EV_STUCK         1
`define SGS_EV_DROP          2
`define SGS_EV_LINE          3
`define SGS_EV_GAP           4
`define SGS_EV_COUNT         5

`endif

//--- core/sgs_supervisor.v
// Synchronous-rectifier gate supervisor with APB register slave
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sgs_consts.vh"

module sgs_supervisor #(
    parameter [15:0] GAP_ENTER_US = `SGS_T_GAP_ENTER_US,
    parameter [15:0] GAP_EXIT_US  = `SGS_T_GAP_EXIT_US,
    parameter [15:0] STUCK_US     = `SGS_T_STUCK_US,
    parameter [15:0] ENABLE_US    = `SGS_T_ENABLE_US,
    parameter [15:0] PWRUP_US     = `SGS_T_PWRUP_US,
    parameter [15:0] LINE_UP_US   = `SGS_T_LINE_UP_US,
    parameter [15:0] LINE_DN_US   = `SGS_T_LINE_DN_US,
    parameter [7:0]  TICK_CYC     = `SGS_TICK_CYC
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        drain_sense,
    input  wire        drain_prev90_low,
    input  wire        drain_between,
    input  wire        output_sense_low,
    input  wire        output_sense_drop,
    input  wire        supply_over_7v,
    input  wire        supply_above_on,
    input  wire        input_sense_low,
    input  wire        line_high_cmp,
    input  wire        cc_mode,
    input  wire        low_line_gain_pin_at_supply,
    input  wire        gain_pins_grounded,
    output reg         sr_gate,
    output reg         idle_mode,
    output reg         drain_sample_clear,
    output reg         cp_double_mode,
    output reg         comp_enable,
    output reg         gain_from_high_pin
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire [`SGS_IN_COUNT-1:0] pin_raw;
    reg  [`SGS_IN_COUNT-1:0] sync1_reg;
    reg  [`SGS_IN_COUNT-1:0] sync2_reg;

    assign pin_raw = {gain_pins_grounded, low_line_gain_pin_at_supply, cc_mode, line_high_cmp,
                      input_sense_low, supply_above_on, supply_over_7v, output_sense_drop,
                      output_sense_low, drain_between, drain_prev90_low, drain_sense};

    genvar gi;
    generate
        for (gi = 0; gi < `SGS_IN_COUNT; gi = gi + 1) begin : g_sync
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    wire drain_s    = sync2_reg[`SGS_IN_DRAIN];
    wire cc_s       = sync2_reg[`SGS_IN_CC_MODE];
    wire supply_ok  = sync2_reg[`SGS_IN_ABOVE_ON];

    // ----------------------------------------------------------------
    // Timebase and edges
    // ----------------------------------------------------------------
    localparam [7:0]  TICK_LAST  = TICK_CYC - 8'h01;
    localparam [15:0] STEP_CYC   = `SGS_STEP_CYC;
    localparam [15:0] DEAD_CVH   = `SGS_DEAD_CVH_CYC;
    localparam [15:0] DEAD_CVL1  = `SGS_DEAD_CVL1_CYC;
    localparam [15:0] DEAD_CVL2  = `SGS_DEAD_CVL2_CYC;
    localparam [15:0] MISS_CV    = `SGS_T_MISS_CV_US;
    localparam [15:0] MISS_CC    = `SGS_T_MISS_CC_US;
    localparam [8:0]  EXIT_CYC   = `SGS_EXIT_CYCLES;
    localparam [8:0]  RESUME_CYC = `SGS_RESUME_CYCLES;

    localparam [2:0] ST_RUN  = 3'h1;
    localparam [2:0] ST_IDLE = 3'h2;
    localparam [2:0] ST_HOLD = 3'h4;

    reg  [7:0]  tick_cnt_reg;
    reg         tick_reg;
    reg         drain_d_reg;
    wire        drain_rise = drain_s & ~drain_d_reg;
    wire        drain_fall = ~drain_s & drain_d_reg;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 8'h00;
            tick_reg     <= 1'b0;
            drain_d_reg  <= 1'b0;
        end else begin
            tick_reg     <= (tick_cnt_reg == TICK_LAST);
            tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 8'h00 : tick_cnt_reg + 8'h01;
            drain_d_reg  <= drain_s;
        end
    end

    // ----------------------------------------------------------------
    // Power-up qualifiers
    // ----------------------------------------------------------------
    reg  [15:0] pwr_ticks_reg;
    reg         drain_ready_reg;
    wire        supply_good_flag      = supply_ok;
    wire        delayed_enable_flag   = supply_ok && (pwr_ticks_reg >= ENABLE_US);
    wire        drain_sense_ready     = drain_ready_reg;
    wire        output_short_flag     = sync2_reg[`SGS_IN_OUT_LOW];
    wire        supply_overvoltage_flag = sync2_reg[`SGS_IN_OVER_7V];

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pwr_ticks_reg   <= 16'h0000;
            drain_ready_reg <= 1'b0;
        end else if (!supply_ok) begin
            pwr_ticks_reg   <= 16'h0000;
            drain_ready_reg <= 1'b0;
        end else begin
            if (tick_reg && pwr_ticks_reg < ENABLE_US) begin
                pwr_ticks_reg <= pwr_ticks_reg + 16'h0001;
            end
            if (drain_s && pwr_ticks_reg >= PWRUP_US) begin
                drain_ready_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Line condition debounce
    // ----------------------------------------------------------------
    reg  [15:0] line_ticks_reg;
    reg         line_high_reg;
    reg         line_change_reg;
    wire        line_raw = sync2_reg[`SGS_IN_LINE_HIGH];
    wire [15:0] line_need = line_high_reg ? LINE_DN_US : LINE_UP_US;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            line_ticks_reg  <= 16'h0000;
            line_high_reg   <= 1'b0;
            line_change_reg <= 1'b0;
        end else begin
            line_change_reg <= 1'b0;
            if (line_raw == line_high_reg) begin
                line_ticks_reg <= 16'h0000;
            end else if (line_ticks_reg >= line_need) begin
                line_high_reg   <= line_raw;
                line_change_reg <= 1'b1;
                line_ticks_reg  <= 16'h0000;
            end else if (tick_reg) begin
                line_ticks_reg <= line_ticks_reg + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Burst gap, missing period and idle mode
    // ----------------------------------------------------------------
    reg  [15:0] gap_ticks_reg;
    reg  [15:0] stuck_ticks_reg;
    reg  [8:0]  cyc_cnt_reg;
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [8:0]  cyc_next;
    wire        missing_period = gap_ticks_reg >= (cc_s ? MISS_CC : MISS_CV);
    wire        ev_prev90 = drain_rise & sync2_reg[`SGS_IN_PREV90_LOW];
    wire        ev_drop   = drain_rise & sync2_reg[`SGS_IN_OUT_DROP];
    wire        ev_stuck  = stuck_ticks_reg >= STUCK_US;
    wire        ev_gap    = (state_reg == ST_RUN) && (gap_ticks_reg > GAP_ENTER_US);
    wire        forced    = (state_reg == ST_RUN) && (ev_prev90 | ev_drop | ev_stuck);

    always @* begin
        state_next = state_reg;
        cyc_next   = cyc_cnt_reg;
        case (state_reg)
            ST_RUN: begin
                cyc_next = 9'h000;
                if (forced) begin
                    state_next = ST_HOLD;
                end else if (ev_gap) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (drain_rise) begin
                    cyc_next = missing_period ? 9'h001 : cyc_cnt_reg + 9'h001;
                    if (gap_ticks_reg < GAP_EXIT_US || cyc_next >= EXIT_CYC) begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_HOLD: begin
                if (drain_rise) begin
                    cyc_next = cyc_cnt_reg + 9'h001;
                    if (cyc_next >= RESUME_CYC) begin
                        state_next = ST_RUN;
                    end
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            gap_ticks_reg      <= 16'h0000;
            stuck_ticks_reg    <= 16'h0000;
            cyc_cnt_reg        <= 9'h000;
            state_reg          <= ST_RUN;
            drain_sample_clear <= 1'b0;
        end else begin
            state_reg          <= state_next;
            cyc_cnt_reg        <= cyc_next;
            drain_sample_clear <= (state_reg == ST_RUN) && ev_stuck;
            if (drain_rise) begin
                gap_ticks_reg <= 16'h0000;
            end else if (tick_reg && gap_ticks_reg != 16'hffff) begin
                gap_ticks_reg <= gap_ticks_reg + 16'h0001;
            end
            // Timer must restart after firing so a stuck level cannot retrigger at once
            if (!sync2_reg[`SGS_IN_BETWEEN] || ev_stuck) begin
                stuck_ticks_reg <= 16'h0000;
            end else if (tick_reg) begin
                stuck_ticks_reg <= stuck_ticks_reg + 16'h0001;
            end
        end
    end

    wire in_idle = (state_reg != ST_RUN);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    reg  [1:0]  ctrl_reg;
    wire        sw_enable   = ctrl_reg[0];
    wire        dead_lo_alt = ctrl_reg[1];

    // ----------------------------------------------------------------
    // Gate drive
    // ----------------------------------------------------------------
    wire gate_allow = ~in_idle & ~output_short_flag & ~supply_overvoltage_flag & ~missing_period
                      & supply_good_flag & delayed_enable_flag & drain_sense_ready & sw_enable;

    reg  [15:0] period_cnt_reg;
    reg  [15:0] last_period_reg;
    reg  [15:0] on_cnt_reg;
    reg  [15:0] limit_reg;
    reg         armed_reg;
    reg         allow_d_reg;
    wire [15:0] dead_cyc = (!line_high_reg && !cc_s) ? (dead_lo_alt ? DEAD_CVL2 : DEAD_CVL1) : DEAD_CVH;
    wire        pred_ok  = last_period_reg > dead_cyc;
    wire [15:0] pred_off = last_period_reg - dead_cyc;
    wire        stop_lim = (on_cnt_reg + 16'h0001) >= limit_reg;
    wire        stop_dead = pred_ok && (period_cnt_reg >= pred_off);
    wire        gate_stop = sr_gate && (stop_lim || stop_dead || drain_rise);
    wire        gate_start = drain_fall && armed_reg && !stop_dead;
    wire        restart = (gate_allow && !allow_d_reg) || line_change_reg;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            period_cnt_reg  <= 16'h0000;
            last_period_reg <= 16'h0000;
            on_cnt_reg      <= 16'h0000;
            limit_reg       <= STEP_CYC;
            armed_reg       <= 1'b0;
            allow_d_reg     <= 1'b0;
            sr_gate         <= 1'b0;
        end else begin
            allow_d_reg <= gate_allow;
            if (drain_rise) begin
                period_cnt_reg  <= 16'h0000;
                last_period_reg <= period_cnt_reg;
            end else if (period_cnt_reg != 16'hffff) begin
                period_cnt_reg <= period_cnt_reg + 16'h0001;
            end
            if (drain_rise) begin
                armed_reg <= 1'b1;
            end else if (gate_start) begin
                armed_reg <= 1'b0;
            end
            if (!gate_allow) begin
                sr_gate    <= 1'b0;
                on_cnt_reg <= 16'h0000;
            end else if (gate_stop) begin
                sr_gate    <= 1'b0;
                on_cnt_reg <= 16'h0000;
            end else if (gate_start) begin
                sr_gate    <= 1'b1;
                on_cnt_reg <= 16'h0000;
            end else if (sr_gate) begin
                on_cnt_reg <= on_cnt_reg + 16'h0001;
            end
            if (restart) begin
                limit_reg <= STEP_CYC;
            end else if (gate_stop) begin
                limit_reg <= on_cnt_reg + 16'h0001 + STEP_CYC;
            end
        end
    end

    // ----------------------------------------------------------------
    // Charge pump and cable compensation selection
    // ----------------------------------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cp_double_mode     <= 1'b0;
            comp_enable        <= 1'b0;
            gain_from_high_pin <= 1'b0;
            idle_mode          <= 1'b1;
        end else begin
            idle_mode          <= in_idle;
            cp_double_mode     <= sync2_reg[`SGS_IN_INPUT_LOW] & ~(in_idle & ~cc_s);
            comp_enable        <= ~sync2_reg[`SGS_IN_GAIN_GND];
            // Strapped low-line pin means the high-line pin sets both gains
            gain_from_high_pin <= line_high_reg | sync2_reg[`SGS_IN_LOW_STRAP];
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    reg  [`SGS_EV_COUNT-1:0] event_reg;
    wire [`SGS_EV_COUNT-1:0] event_set = {ev_gap, line_change_reg, forced & ev_drop,
                                          forced & ev_stuck, forced & ev_prev90};
    wire        wr_en = psel && penable && pwrite;
    wire        mapped = (paddr == `SGS_ADDR_CTRL) || (paddr == `SGS_ADDR_STATUS) ||
                         (paddr == `SGS_ADDR_ONTIME) || (paddr == `SGS_ADDR_PERIOD) ||
                         (paddr == `SGS_ADDR_EVENT);
    wire [31:0] status_word = {18'h00000, cc_s, gain_from_high_pin, comp_enable, cp_double_mode,
                               drain_sense_ready, delayed_enable_flag, supply_good_flag,
                               missing_period, supply_overvoltage_flag, output_short_flag,
                               sr_gate, line_high_reg, state_reg == ST_HOLD, in_idle};
    reg  [31:0] rd_word;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always @* begin
        if (paddr == `SGS_ADDR_CTRL) begin
            rd_word = {30'h00000000, ctrl_reg};
        end else if (paddr == `SGS_ADDR_STATUS) begin
            rd_word = status_word;
        end else if (paddr == `SGS_ADDR_ONTIME) begin
            rd_word = {16'h0000, limit_reg};
        end else if (paddr == `SGS_ADDR_PERIOD) begin
            rd_word = {16'h0000, last_period_reg};
        end else if (paddr == `SGS_ADDR_EVENT) begin
            rd_word = {27'h0000000, event_reg};
        end else begin
            rd_word = 32'h00000000;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg  <= `SGS_CTRL_RESET;
            event_reg <= {`SGS_EV_COUNT{1'b0}};
            prdata    <= 32'h00000000;
        end else begin
            if (psel && !penable) begin
                prdata <= rd_word;
            end
            if (wr_en && paddr == `SGS_ADDR_CTRL) begin
                ctrl_reg <= pwdata[1:0];
            end
            // Set wins over a clear in the same cycle
            if (wr_en && paddr == `SGS_ADDR_EVENT) begin
                event_reg <= (event_reg & ~pwdata[`SGS_EV_COUNT-1:0]) | event_set;
            end else begin
                event_reg <= event_reg | event_set;
            end
        end
    end

endmodule
`default_nettype wire

//--- tb/sgs_props.sv
// Concurrent checks on the gate supervisor ports
`timescale 1ns/1ps
`default_nettype none
module sgs_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic supply_over_7v,
    input wire logic output_sense_low,
    input wire logic supply_above_on,
    input wire logic input_sense_low,
    input wire logic cc_mode,
    input wire logic sr_gate,
    input wire logic idle_mode,
    input wire logic drain_sample_clear,
    input wire logic cp_double_mode
);
    // Six cycles cover the input synchroniser plus the output register
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence cv_idle_s; (idle_mode && !cc_mode) [*6]; endsequence
    sequence doubling_s; (input_sense_low && !idle_mode) [*6]; endsequence
    ovp_gate_off_a: assert property (supply_over_7v [*6] |-> !sr_gate)
        else $error("Gate high under overvoltage");
    short_gate_off_a: assert property (output_sense_low [*6] |-> !sr_gate)
        else $error("Gate high with output shorted");
    idle_gate_off_a: assert property (idle_mode [*2] |-> !sr_gate)
        else $error("Gate high in idle");
    supply_gate_off_a: assert property (!supply_above_on [*6] |-> !sr_gate)
        else $error("Gate high without supply");
    clear_to_idle_a: assert property (drain_sample_clear |-> ##[0:2] idle_mode)
        else $error("Sample clear without idle");
    idle_bypass_a: assert property (cv_idle_s |-> !cp_double_mode)
        else $error("Doubling left on in idle");
    doubling_on_a: assert property (doubling_s |-> cp_double_mode)
        else $error("Doubling missing at low input");
    bypass_on_a: assert property (!input_sense_low [*6] |-> !cp_double_mode)
        else $error("Doubling at high input");
endmodule
bind sgs_supervisor sgs_props sgs_props_i (.clock, .rst, .supply_over_7v, .output_sense_low, .supply_above_on,
    .input_sense_low, .cc_mode, .sr_gate, .idle_mode, .drain_sample_clear, .cp_double_mode);
`default_nettype wire

//--- tb/sgs_primary_model.sv
// Primary switch as seen through the secondary winding sense
`timescale 1ns/1ps
`default_nettype none
module sgs_primary_model (
    input  wire logic       clock,
    input  wire logic       run,
    input  wire logic [9:0] hi_cyc,
    input  wire logic [9:0] lo_cyc,
    output var  logic       drain_sense
);
    logic [10:0] cnt = 11'h000;
    initial drain_sense = 1'b0;
    // Sense stays low between bursts, so a stopped switch reads as a gap
    always @(posedge clock) begin
        if (!run || cnt >= {1'b0, hi_cyc} + {1'b0, lo_cyc} - 11'h001)
            cnt <= 11'h000;
        else
            cnt <= cnt + 11'h001;
        drain_sense <= run && (cnt < {1'b0, hi_cyc});
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the gate supervisor
`timescale 1ns/1ps
`default_nettype none
`include "sgs_consts.vh"
module tb_top;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, err, run, d_q, gate_seen, cc_mode;
    logic        drain_sense, drain_prev90_low, drain_between, output_sense_low, output_sense_drop, idle_mode;
    logic        supply_over_7v, supply_above_on, input_sense_low, line_high_cmp, low_line_gain_pin_at_supply;
    logic        gain_pins_grounded, sr_gate;
    logic        drain_sample_clear, cp_double_mode, comp_enable, gain_from_high_pin, clr_seen;
    logic [7:0]  paddr;
    logic [9:0]  hi_c, lo_c;
    logic [31:0] pwdata, prdata, rd;
    int          rises, cyc, w, wp, n_mismatch, check_count;
    // ----------------------------------------
    // Shortened durations, one tick is twenty clocks
    // Missing-period limit stays fixed, so the tick must leave room for a grown gate
    // ----------------------------------------
    sgs_supervisor #(.GAP_ENTER_US(16'h0021), .GAP_EXIT_US(16'h000f), .STUCK_US(16'h0028), .ENABLE_US(16'h0014),
        .PWRUP_US(16'h0005), .LINE_UP_US(16'h0014), .LINE_DN_US(16'h0003), .TICK_CYC(8'h14)) sgs_supervisor_i (
        .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .drain_sense,
        .drain_prev90_low, .drain_between, .output_sense_low, .output_sense_drop, .supply_over_7v, .supply_above_on,
        .input_sense_low, .line_high_cmp, .cc_mode, .low_line_gain_pin_at_supply, .gain_pins_grounded, .sr_gate,
        .idle_mode, .drain_sample_clear, .cp_double_mode, .comp_enable, .gain_from_high_pin);
    sgs_primary_model sgs_primary_model_i (.clock, .run, .hi_cyc(hi_c), .lo_cyc(lo_c), .drain_sense);
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        d_q <= drain_sense;
        cyc <= cyc + 1;
        if (drain_sense && !d_q)
            rises <= rises + 1;
        if (sr_gate === 1'b1)
            gate_seen <= 1'b1;
        if (drain_sample_clear === 1'b1)
            clr_seen <= 1'b1;
        if (cyc == 60000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic t_regs();
        apb(1'b0, `SGS_ADDR_ONTIME, 32'h0);
        check("ontime reset", rd, 32'h64);
        apb(1'b1, 8'h20, 32'hffffffff);
        check("unmapped error", {31'h0, err}, 32'h1);
        $display("t_regs done");
    endtask
    task automatic t_soft();
        input_sense_low <= 1'b0;
        supply_above_on <= 1'b1;
        lo_c <= 10'h0f0;
        run <= 1'b1;
        wp = 0;
        for (int i = 0; i < 4; i++) begin
            w = 0;
            do @(posedge clock); while (sr_gate !== 1'b1);
            do begin
                @(posedge clock);
                w++;
            end while (sr_gate === 1'b1);
            check("gate width step", {31'h0, w > 0 && w <= wp + 101}, 32'h1);
            wp = w;
        end
        check("gate grew", {31'h0, wp > 101}, 32'h1);
        check("dead time margin", {31'h0, w + `SGS_DEAD_CVL1_CYC <= 241}, 32'h1);
        $display("t_soft done");
    endtask
    task automatic t_disable();
        for (int k = 0; k < 2; k++) begin
            {supply_over_7v, output_sense_low} <= 2'h1 << k;
            repeat (10) @(posedge clock);
            gate_seen = 1'b0;
            repeat (700) @(posedge clock);
            apb(1'b0, `SGS_ADDR_STATUS, 32'h0);
            check("status disable bit", {31'h0, rd[4 + k]}, 32'h1);
            check("gate held off", {31'h0, gate_seen}, 32'h0);
            {supply_over_7v, output_sense_low} <= 2'h0;
            repeat (2) @(posedge clock);
        end
        $display("t_disable done");
    endtask
    task automatic t_fault();
        lo_c <= 10'h010;
        hi_c <= 10'h008;
        for (int k = 0; k < 3; k++) begin
            clr_seen = 1'b0;
            repeat (300) @(posedge clock);
            {output_sense_drop, drain_between, drain_prev90_low} <= 3'h1 << k;
            do @(posedge clock); while (idle_mode !== 1'b1);
            {output_sense_drop, drain_between, drain_prev90_low} <= 3'h0;
            wp = rises;
            do @(posedge clock); while (idle_mode !== 1'b0);
            check("hold rise count", {31'h0, rises - wp >= 254 && rises - wp <= 258}, 32'h1);
            apb(1'b0, `SGS_ADDR_EVENT, 32'h0);
            check("fault event", {31'h0, rd[k]}, 32'h1);
            check("sample clear", {31'h0, clr_seen}, {31'h0, k == 1});
            apb(1'b1, `SGS_ADDR_EVENT, 32'h1f);
        end
        $display("t_fault done");
    endtask
    task automatic t_gap();
        run <= 1'b0;
        input_sense_low <= 1'b1;
        repeat (800) @(posedge clock);
        check("long gap idle", {31'h0, idle_mode}, 32'h1);
        check("idle cv bypass", {31'h0, cp_double_mode}, 32'h0);
        apb(1'b0, `SGS_ADDR_STATUS, 32'h0);
        check("missing period", {31'h0, rd[6]}, 32'h1);
        cc_mode <= 1'b1;
        repeat (5) @(posedge clock);
        check("idle cc doubling", {31'h0, cp_double_mode}, 32'h1);
        cc_mode <= 1'b0;
        run <= 1'b1;
        repeat (100) @(posedge clock);
        check("short gap exit", {31'h0, idle_mode}, 32'h0);
        apb(1'b0, `SGS_ADDR_EVENT, 32'h0);
        check("gap event", {31'h0, rd[4]}, 32'h1);
        $display("t_gap done");
    endtask
    task automatic t_straps();
        check("run doubling", {31'h0, cp_double_mode}, 32'h1);
        check("grounded gains", {31'h0, comp_enable}, 32'h0);
        check("strapped low pin", {31'h0, gain_from_high_pin}, 32'h1);
        {gain_pins_grounded, low_line_gain_pin_at_supply, line_high_cmp} <= 3'h1;
        repeat (200) @(posedge clock);
        check("comp enabled", {31'h0, comp_enable}, 32'h1);
        check("line up debounce", {31'h0, gain_from_high_pin}, 32'h0);
        repeat (300) @(posedge clock);
        check("high line gain", {31'h0, gain_from_high_pin}, 32'h1);
        line_high_cmp <= 1'b0;
        repeat (100) @(posedge clock);
        check("low line gain", {31'h0, gain_from_high_pin}, 32'h0);
        apb(1'b0, `SGS_ADDR_STATUS, 32'h0);
        check("power up flags", {29'h0, rd[9:7]}, 32'h7);
        apb(1'b0, `SGS_ADDR_EVENT, 32'h0);
        check("line event", {31'h0, rd[3]}, 32'h1);
        $display("t_straps done");
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, run, lo_c, d_q, gate_seen, cc_mode, clr_seen} = '0;
        {drain_prev90_low, drain_between, output_sense_low, output_sense_drop, supply_over_7v} = '0;
        {supply_above_on, line_high_cmp, rises, cyc, n_mismatch, check_count} = '0;
        {input_sense_low, low_line_gain_pin_at_supply, gain_pins_grounded} = 3'h7;
        hi_c = 10'h028;
        rst = 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_soft();
        t_disable();
        t_fault();
        t_gap();
        t_straps();
        results();
    end
endmodule
`default_nettype wire
